// *** hw/asp_top.sv ***
// Asynchronous serial port with one-deep transmit and receive buffers behind APB.
// Assumes APB signals and the line inputs are synchronous to pclk.
//
// Operation
// - Transmit one or two stop bits
// - Optional parity, odd when sense zero
// - Armed buffer write clears empty, starts frame
// - Frame start sets empty flag, transmit interrupt
// - Line high while disabled or nothing written
// - Buffer write needs prior status read
// - Stop received loads data, full flag, interrupt
// - Overrun keeps old buffer, sets flag
// - Receive disable waits for frame end
// - Parity mismatch sets parity error
// - Stop sampled low sets framing error
// - Status then buffer read clears flags
// - No reception while overrun set
// - Late overrun survives buffer read
// - Transmit end set idle, cleared on start
// - Baud select divides clock or uses timer
// - Disable waits frame end, stale word dropped
// - Shared baud and parity both directions
// - Enables control directions, control write-only
// - Majority of ticks seven, eight, nine
// - Sixteen ticks per bit
// - Start low, eight data LSB first
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module asp_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        baud_timer_interrupt,
  input  wire logic        rx_line,
  output logic             tx_line,
  output logic             tx_interrupt,
  output logic             rx_interrupt
);
  import asp_pkg::*;

  logic [7:0]  ctrl_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        tx_armed_ff;
  logic        rx_armed_ff;
  logic        oerr_seen_ff;
  logic [8:0]  div_cnt_ff;
  logic        tick_ff;
  logic [8:0]  div_lim;
  asp_tx_st_t  tx_st_ff;
  logic [3:0]  tx_tick_ff;
  logic [2:0]  tx_idx_ff;
  logic [7:0]  tx_shift_ff;
  logic [7:0]  tx_data_ff;
  logic        tx_pend_ff;
  logic        tx_run_ff;
  logic        tx_buffer_empty_flag_ff;
  logic        tx_end_flag_ff;
  logic        tx_line_ff;
  logic        tx_irq_ff;
  asp_rx_st_t  rx_st_ff;
  logic [3:0]  rx_tick_ff;
  logic [2:0]  rx_idx_ff;
  logic [7:0]  rx_shift_ff;
  logic        rx_par_ff;
  logic        s7_ff;
  logic        s8_ff;
  logic [7:0]  rx_buf_ff;
  logic        rx_run_ff;
  logic        rbfl_ff;
  logic        parity_error_flag_ff;
  logic        framing_error_flag_ff;
  logic        oerr_ff;
  logic        rx_irq_ff;
  logic        acc;
  logic        setup;
  logic        hit;
  logic        stat_rd;
  logic        txbuf_wr;
  logic        rxbuf_rd;
  logic        maj;
  logic        exp_par;
  logic        tx_bit_end;

  // Shared parity and baud settings for both directions.
  wire par_en  = ctrl_ff[ASP_CTL_PE];
  wire par_evn = ctrl_ff[ASP_CTL_EVEN];
  wire two_stp = ctrl_ff[ASP_CTL_STOP];
  wire [2:0] baud_clock_select = ctrl_ff[ASP_CTL_BRGL +: 3];

  // APB phase decode; access completes when pready was raised.
  assign setup    = psel & ~penable;
  assign acc      = psel & penable & pready_ff;
  assign hit      = (paddr == ASP_OFS_CTRL) | (paddr == ASP_OFS_STATUS) |
                    (paddr == ASP_OFS_TXBUF) | (paddr == ASP_OFS_RXBUF);
  assign stat_rd  = acc & ~pwrite & (paddr == ASP_OFS_STATUS);
  assign txbuf_wr = acc & pwrite & (paddr == ASP_OFS_TXBUF) & tx_armed_ff;
  assign rxbuf_rd = acc & ~pwrite & (paddr == ASP_OFS_RXBUF) & rx_armed_ff;

  // Ready, error and read data are prepared during the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~hit;
      prdata_ff  <= 32'h0000_0000;
      if (setup & ~pwrite & (paddr == ASP_OFS_STATUS)) begin
        prdata_ff <= {24'h00_0000, parity_error_flag_ff, framing_error_flag_ff, oerr_ff, rbfl_ff,
                      tx_end_flag_ff, tx_buffer_empty_flag_ff, 2'b00};
      end else if (setup & ~pwrite & (paddr == ASP_OFS_RXBUF)) begin
        prdata_ff <= {24'h00_0000, rx_buf_ff};
      end
    end
  end

  // Control register is write-only and reads back as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= ASP_CTRL_RST;
    end else if (acc & pwrite & (paddr == ASP_OFS_CTRL)) begin
      ctrl_ff <= pwdata[7:0];
    end
  end

  // Status read arms the following buffer accesses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_armed_ff  <= 1'b0;
      rx_armed_ff  <= 1'b0;
      oerr_seen_ff <= 1'b0;
    end else if (stat_rd) begin
      tx_armed_ff  <= 1'b1;
      rx_armed_ff  <= 1'b1;
      oerr_seen_ff <= oerr_ff;
    end else begin
      if (acc & pwrite & (paddr == ASP_OFS_TXBUF)) begin
        tx_armed_ff <= 1'b0;
      end
      if (acc & ~pwrite & (paddr == ASP_OFS_RXBUF)) begin
        rx_armed_ff <= 1'b0;
      end
    end
  end

  // Divide count for the selected baud clock.
  always_comb begin
    case (baud_clock_select)
      3'h0:    div_lim = ASP_DIV_13;
      3'h1:    div_lim = ASP_DIV_26;
      3'h2:    div_lim = ASP_DIV_52;
      3'h3:    div_lim = ASP_DIV_104;
      3'h4:    div_lim = ASP_DIV_208;
      3'h5:    div_lim = ASP_DIV_416;
      3'h7:    div_lim = ASP_DIV_96;
      default: div_lim = ASP_DIV_13;
    endcase
  end

  // Sampling tick generator: one pulse per transfer clock period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 9'h000;
      tick_ff    <= 1'b0;
    end else if (baud_clock_select == ASP_BRG_TIMER) begin
      div_cnt_ff <= 9'h000;
      tick_ff    <= baud_timer_interrupt;
    end else if (div_cnt_ff >= div_lim - 9'h001) begin
      div_cnt_ff <= 9'h000;
      tick_ff    <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 9'h001;
      tick_ff    <= 1'b0;
    end
  end

  assign tx_bit_end = tick_ff & (tx_tick_ff == ASP_TICK_LAST);

  // Transmitter: buffer, flags, frame sequencing and line drive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_ff    <= ASP_TX_IDLE;
      tx_tick_ff  <= 4'h0;
      tx_idx_ff   <= 3'h0;
      tx_shift_ff <= 8'h00;
      tx_data_ff  <= 8'h00;
      tx_pend_ff  <= 1'b0;
      tx_run_ff   <= 1'b0;
      tx_buffer_empty_flag_ff     <= 1'b1;
      tx_end_flag_ff     <= 1'b1;
      tx_line_ff  <= 1'b1;
      tx_irq_ff   <= 1'b0;
    end else begin
      tx_irq_ff <= 1'b0;
      if (tick_ff && tx_st_ff != ASP_TX_IDLE) begin
        tx_tick_ff <= tx_tick_ff + 4'h1;
      end
      case (tx_st_ff)
        ASP_TX_IDLE: begin
          tx_line_ff <= 1'b1;
          tx_run_ff  <= ctrl_ff[ASP_CTL_TXE];
          if (!tx_run_ff) begin
            tx_pend_ff <= 1'b0;
          // Start only on a tick so that the start bit lasts sixteen full ticks.
          end else if (tx_pend_ff && tick_ff) begin
            tx_shift_ff <= tx_data_ff;
            tx_pend_ff  <= 1'b0;
            tx_buffer_empty_flag_ff     <= 1'b1;
            tx_irq_ff   <= 1'b1;
            tx_end_flag_ff     <= 1'b0;
            tx_line_ff  <= 1'b0;
            tx_tick_ff  <= 4'h0;
            tx_st_ff    <= ASP_TX_START;
          end
        end
        ASP_TX_START: begin
          if (tx_bit_end) begin
            tx_idx_ff  <= 3'h0;
            tx_line_ff <= tx_shift_ff[0];
            tx_st_ff   <= ASP_TX_DATA;
          end
        end
        ASP_TX_DATA: begin
          if (tx_bit_end) begin
            if (tx_idx_ff != ASP_LAST_DATA) begin
              tx_idx_ff  <= tx_idx_ff + 3'h1;
              tx_line_ff <= tx_shift_ff[tx_idx_ff + 3'h1];
            end else if (par_en) begin
              tx_line_ff <= par_evn ? ^tx_shift_ff : ~^tx_shift_ff;
              tx_st_ff   <= ASP_TX_PAR;
            end else begin
              tx_line_ff <= 1'b1;
              tx_st_ff   <= ASP_TX_STOP1;
            end
          end
        end
        ASP_TX_PAR: begin
          if (tx_bit_end) begin
            tx_line_ff <= 1'b1;
            tx_st_ff   <= ASP_TX_STOP1;
          end
        end
        ASP_TX_STOP1, ASP_TX_STOP2: begin
          if (tx_bit_end) begin
            if (tx_st_ff == ASP_TX_STOP1 && two_stp) begin
              tx_st_ff <= ASP_TX_STOP2;
            end else begin
              tx_st_ff <= ASP_TX_IDLE;
              if (!tx_pend_ff) begin
                tx_end_flag_ff <= 1'b1;
              end
            end
          end
        end
        default: begin
          tx_st_ff   <= ASP_TX_IDLE;
          tx_line_ff <= 1'b1;
        end
      endcase
      // Accepted buffer write; placed last so a same-cycle frame start or disabled-idle clear cannot undo it.
      if (txbuf_wr) begin
        tx_data_ff <= pwdata[7:0];
        tx_pend_ff <= 1'b1;
        tx_buffer_empty_flag_ff    <= 1'b0;
      end
    end
  end

  // Majority of the three mid-bit samples.
  assign maj     = (s7_ff & s8_ff) | (s7_ff & rx_line) | (s8_ff & rx_line);
  assign exp_par = par_evn ? ^rx_shift_ff : ~^rx_shift_ff;

  // Receiver: start detect, sampling, buffer and error flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_ff    <= ASP_RX_IDLE;
      rx_tick_ff  <= 4'h0;
      rx_idx_ff   <= 3'h0;
      rx_shift_ff <= 8'h00;
      rx_par_ff   <= 1'b0;
      s7_ff       <= 1'b1;
      s8_ff       <= 1'b1;
      rx_buf_ff   <= 8'h00;
      rx_run_ff   <= 1'b0;
      rbfl_ff     <= 1'b0;
      parity_error_flag_ff     <= 1'b0;
      framing_error_flag_ff     <= 1'b0;
      oerr_ff     <= 1'b0;
      rx_irq_ff   <= 1'b0;
    end else begin
      rx_irq_ff <= 1'b0;
      // Buffer read after status read clears flags; sets below win.
      if (rxbuf_rd) begin
        rbfl_ff <= 1'b0;
        parity_error_flag_ff <= 1'b0;
        framing_error_flag_ff <= 1'b0;
        if (oerr_seen_ff) begin
          oerr_ff <= 1'b0;
        end
      end
      if (tick_ff && rx_st_ff != ASP_RX_IDLE) begin
        rx_tick_ff <= rx_tick_ff + 4'h1;
        if (rx_tick_ff == ASP_TICK_S7) begin
          s7_ff <= rx_line;
        end
        if (rx_tick_ff == ASP_TICK_S8) begin
          s8_ff <= rx_line;
        end
      end
      case (rx_st_ff)
        ASP_RX_IDLE: begin
          rx_run_ff <= ctrl_ff[ASP_CTL_RXE];
          if (tick_ff && rx_run_ff && !oerr_ff && !rx_line) begin
            rx_tick_ff <= 4'h1;
            rx_st_ff   <= ASP_RX_START;
          end
        end
        ASP_RX_START: begin
          if (tick_ff && rx_tick_ff == ASP_TICK_S9 && maj) begin
            rx_st_ff <= ASP_RX_IDLE;
          end else if (tick_ff && rx_tick_ff == ASP_TICK_LAST) begin
            rx_idx_ff <= 3'h0;
            rx_st_ff  <= ASP_RX_DATA;
          end
        end
        ASP_RX_DATA: begin
          if (tick_ff && rx_tick_ff == ASP_TICK_S9) begin
            rx_shift_ff <= {maj, rx_shift_ff[7:1]};
          end
          if (tick_ff && rx_tick_ff == ASP_TICK_LAST) begin
            rx_idx_ff <= rx_idx_ff + 3'h1;
            if (rx_idx_ff == ASP_LAST_DATA) begin
              rx_st_ff <= par_en ? ASP_RX_PAR : ASP_RX_STOP;
            end
          end
        end
        ASP_RX_PAR: begin
          if (tick_ff && rx_tick_ff == ASP_TICK_S9) begin
            rx_par_ff <= maj;
          end
          if (tick_ff && rx_tick_ff == ASP_TICK_LAST) begin
            rx_st_ff <= ASP_RX_STOP;
          end
        end
        ASP_RX_STOP: begin
          if (tick_ff && rx_tick_ff == ASP_TICK_S9) begin
            rx_st_ff <= ASP_RX_IDLE;
            if (!maj) begin
              framing_error_flag_ff <= 1'b1;
            end
            if (par_en && rx_par_ff != exp_par) begin
              parity_error_flag_ff <= 1'b1;
            end
            if (rbfl_ff && !rxbuf_rd) begin
              oerr_ff <= 1'b1;
            end else begin
              rx_buf_ff <= rx_shift_ff;
              rbfl_ff   <= 1'b1;
              rx_irq_ff <= 1'b1;
            end
          end
        end
        default: begin
          rx_st_ff <= ASP_RX_IDLE;
        end
      endcase
    end
  end

  // Outputs come straight from flops.
  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign tx_line      = tx_line_ff;
  assign tx_interrupt = tx_irq_ff;
  assign rx_interrupt = rx_irq_ff;

endmodule : asp_top

// *** hw/asp_pkg.sv ***
// Constants for the asynchronous serial port: register map, fields, reset values, timing.
// Assumes an APB master with 32-bit data and a 100 MHz pclk.
package asp_pkg;

  // Register byte offsets.
  localparam logic [7:0] ASP_OFS_CTRL   = 8'h00;
  localparam logic [7:0] ASP_OFS_STATUS = 8'h04;
  localparam logic [7:0] ASP_OFS_TXBUF  = 8'h08;
  localparam logic [7:0] ASP_OFS_RXBUF  = 8'h0c;

  // Control field positions.
  localparam int ASP_CTL_TXE  = 7;
  localparam int ASP_CTL_RXE  = 6;
  localparam int ASP_CTL_STOP = 5;
  localparam int ASP_CTL_EVEN = 4;
  localparam int ASP_CTL_PE   = 3;
  localparam int ASP_CTL_BRGL = 0;

  // Reset values.
  localparam logic [7:0] ASP_CTRL_RST = 8'h00;

  // Baud clock select codes and divide counts.
  localparam logic [2:0] ASP_BRG_TIMER = 3'h6;
  localparam logic [8:0] ASP_DIV_13  = 9'h00d;
  localparam logic [8:0] ASP_DIV_26  = 9'h01a;
  localparam logic [8:0] ASP_DIV_52  = 9'h034;
  localparam logic [8:0] ASP_DIV_104 = 9'h068;
  localparam logic [8:0] ASP_DIV_208 = 9'h0d0;
  localparam logic [8:0] ASP_DIV_416 = 9'h1a0;
  localparam logic [8:0] ASP_DIV_96  = 9'h060;

  // Sampling ticks within one bit.
  localparam logic [3:0] ASP_TICK_LAST = 4'hf;
  localparam logic [3:0] ASP_TICK_S7   = 4'h7;
  localparam logic [3:0] ASP_TICK_S8   = 4'h8;
  localparam logic [3:0] ASP_TICK_S9   = 4'h9;
  localparam logic [2:0] ASP_LAST_DATA = 3'h7;

  typedef enum logic [2:0] {
    ASP_TX_IDLE  = 3'b000,
    ASP_TX_START = 3'b001,
    ASP_TX_DATA  = 3'b010,
    ASP_TX_PAR   = 3'b011,
    ASP_TX_STOP1 = 3'b100,
    ASP_TX_STOP2 = 3'b101
  } asp_tx_st_t;

  typedef enum logic [2:0] {
    ASP_RX_IDLE  = 3'b000,
    ASP_RX_START = 3'b001,
    ASP_RX_DATA  = 3'b010,
    ASP_RX_PAR   = 3'b011,
    ASP_RX_STOP  = 3'b100
  } asp_rx_st_t;

endpackage : asp_pkg

// *** sim/asp_top_properties.sv ***
// Concurrent checks on the serial port's APB and line ports.
// Bound to asp_top and sees only its ports.
`timescale 1ns/1ns
module asp_top_properties
  import asp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        baud_timer_interrupt,
  input wire logic        rx_line,
  input wire logic        tx_line,
  input wire logic        tx_interrupt,
  input wire logic        rx_interrupt
);
  import asp_pkg::*;
  logic rd_q;

  // All checks share one clock and the bus reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A completed read access.
  assign rd_q = pready && !pwrite;

  pready_one_a: assert property (pready |=> !pready) else $error("pready held two cycles");
  setup_ans_a: assert property (psel && !penable |=> pready) else $error("access not answered");
  err_map_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > ASP_OFS_RXBUF))
    else $error("slave error on wrong address");
  ctrl_wo_a: assert property (rd_q && paddr == ASP_OFS_CTRL |-> prdata == 32'h0)
    else $error("control read not zero");
  stat_end_a: assert property (rd_q && paddr == ASP_OFS_STATUS && prdata[3] |-> prdata[2])
    else $error("end flag without empty flag");
  txirq_pulse_a: assert property (tx_interrupt |=> !tx_interrupt)
    else $error("transmit interrupt too long");
  rxirq_pulse_a: assert property (rx_interrupt |=> !rx_interrupt)
    else $error("receive interrupt too long");
  tx_start_a: assert property (tx_interrupt |-> ##[0:2] !tx_line)
    else $error("no start bit after frame start");
  bit_hold_a: assert property ($changed(tx_line) |=> $stable(tx_line) [*8])
    else $error("transmit bit too short");
  idle_rst_a: assert property ($rose(presetn) |-> tx_line)
    else $error("line not idle after reset");

  // Main scenarios seen.
  cov_tx: cover property (tx_interrupt);
  cov_rx: cover property (rx_interrupt);
  cov_err: cover property (pready && pslverr);
endmodule : asp_top_properties

bind asp_top asp_top_properties u_asp_top_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .baud_timer_interrupt(baud_timer_interrupt), .rx_line(rx_line), .tx_line(tx_line),
  .tx_interrupt(tx_interrupt), .rx_interrupt(rx_interrupt));

// *** sim/asp_remote.sv ***
// Remote serial transceiver: decodes frames from tx_line, sends frames on rx_line.
// Bit length in pclk cycles is set by the bench in bit_cyc.
`timescale 1ns/1ns
module asp_remote (
  input wire logic pclk,
  input wire logic tx_line,
  output logic     rx_line
);
  int         bit_cyc = 208;
  int         frames  = 0;
  int         got_low = 0;
  int         lowcnt  = 0;
  int         gap     = 0;
  time        t_start = 0;
  logic [9:0] bits;
  logic [7:0] got_d, prev_d;
  logic       got_p;

  initial rx_line = 1'b1;

  // Samples each frame mid-bit and keeps data, parity and start spacing.
  always begin
    @(negedge tx_line);
    gap = int'(($time - t_start) / 10);
    t_start = $time;
    repeat (bit_cyc / 2) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      repeat (bit_cyc) @(posedge pclk);
      bits[i] = tx_line;
    end
    prev_d = got_d;
    got_d = bits[7:0];
    got_p = bits[8];
    frames++;
  end

  // Measures the length of each low run on the line.
  always @(posedge pclk) begin
    if (!tx_line) begin
      lowcnt++;
    end else if (lowcnt != 0) begin
      got_low = lowcnt;
      lowcnt = 0;
    end
  end

  // Sends start, data LSB first, parity slot, one stop, then one idle bit.
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    logic [10:0] f;
    f = {s, p, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      repeat (bit_cyc) @(posedge pclk);
    end
    rx_line <= 1'b1;
    repeat (bit_cyc) @(posedge pclk);
  endtask : send
endmodule : asp_remote

// *** sim/tb_asp_top.sv ***
// Self-checking bench for the serial port: APB tasks and a remote transceiver.
// Runs at 100 MHz; expectations come from the package offsets and field layout.
`timescale 1ns/1ns
module tb_asp_top;
  import asp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, tmr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, rx_line, tx_line, tx_interrupt, rx_interrupt, e;
  int          errors = 0, samples_checked = 0, ntx = 0, nrx = 0, tdiv = 0, tcnt = 0;
  logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h6};
  int          divs  [5] = '{13, 26, 52, 96, 4};

  asp_top u_asp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .baud_timer_interrupt(tmr), .rx_line(rx_line), .tx_line(tx_line),
    .tx_interrupt(tx_interrupt), .rx_interrupt(rx_interrupt));
  asp_remote u_asp_remote (.pclk(pclk), .tx_line(tx_line), .rx_line(rx_line));

  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Timer pulse every four cycles and interrupt pulse counters.
  always @(posedge pclk) begin
    tcnt <= (tcnt == 3) ? 0 : tcnt + 1;
    tmr <= (tdiv != 0) && (tcnt == 3);
    ntx <= ntx + int'(tx_interrupt === 1'b1);
    nrx <= nrx + int'(rx_interrupt === 1'b1);
  end

  task automatic stop_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until pready is sampled high; only the watchdog ends a hang.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd

  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (u_asp_remote.frames < n && k < 40000) begin
      @(posedge pclk);
      k++;
    end
    chk(u_asp_remote.frames, n);
  endtask : wait_frames

  // Watchdog against a hung bus or line.
  initial begin
    repeat (90000) @(posedge pclk);
    errors++;
    stop_test;
  end

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, ASP_OFS_CTRL, 32'hb8);
    apb(1'b1, ASP_OFS_TXBUF, 32'h55);
    repeat (300) @(posedge pclk);
    chk(u_asp_remote.frames, 0);
    chk(tx_line, 1'b1);
    rd(ASP_OFS_STATUS, 32'h0c);
    rd(ASP_OFS_CTRL, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({r[30:0], e}, 32'h1);
    rd(ASP_OFS_STATUS, 32'h0c);
    apb(1'b1, ASP_OFS_TXBUF, 32'ha5);
    // A frame starts on the next sampling tick, at most one divide period later.
    repeat (16) @(posedge pclk);
    rd(ASP_OFS_STATUS, 32'h04);
    apb(1'b1, ASP_OFS_TXBUF, 32'h3c);
    rd(ASP_OFS_STATUS, 32'h00);
    wait_frames(2);
    chk(u_asp_remote.prev_d, 32'ha5);
    chk(u_asp_remote.got_d, 32'h3c);
    chk(u_asp_remote.got_p, ^8'h3c);
    // Twelve bits of sixteen ticks at divide 13, plus at most one tick of idle.
    chk(u_asp_remote.gap >= 2496 && u_asp_remote.gap <= 2496 + 13, 1'b1);
    repeat (460) @(posedge pclk);
    rd(ASP_OFS_STATUS, 32'h0c);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, ASP_OFS_CTRL, 32'h0);
      tdiv = int'(k == 4);
      apb(1'b1, ASP_OFS_CTRL, {24'h0, 5'h15, codes[k]});
      u_asp_remote.bit_cyc = 16 * divs[k];
      rd(ASP_OFS_STATUS, 32'h0c);
      apb(1'b1, ASP_OFS_TXBUF, 32'hff);
      wait_frames(3 + k);
      chk(u_asp_remote.got_low, 16 * divs[k]);
      chk(u_asp_remote.got_p, 1'b1);
      repeat (48 * divs[k]) @(posedge pclk);
    end
    apb(1'b1, ASP_OFS_CTRL, 32'h0);
    apb(1'b1, ASP_OFS_CTRL, 32'h48);
    u_asp_remote.bit_cyc = 208;
    u_asp_remote.send(8'h3c, ~^8'h3c, 1'b1);
    rd(ASP_OFS_STATUS, 32'h1c);
    rd(ASP_OFS_RXBUF, 32'h3c);
    rd(ASP_OFS_STATUS, 32'h0c);
    u_asp_remote.send(8'h11, ~^8'h11, 1'b1);
    u_asp_remote.send(8'h22, ~^8'h22, 1'b1);
    rd(ASP_OFS_STATUS, 32'h3c);
    rd(ASP_OFS_RXBUF, 32'h11);
    rd(ASP_OFS_STATUS, 32'h0c);
    u_asp_remote.send(8'h33, ~^8'h33, 1'b1);
    rd(ASP_OFS_STATUS, 32'h1c);
    rd(ASP_OFS_RXBUF, 32'h33);
    u_asp_remote.send(8'h44, ~^8'h44, 1'b1);
    rd(ASP_OFS_STATUS, 32'h1c);
    u_asp_remote.send(8'h66, ~^8'h66, 1'b1);
    rd(ASP_OFS_RXBUF, 32'h44);
    u_asp_remote.send(8'h77, ~^8'h77, 1'b1);
    rd(ASP_OFS_STATUS, 32'h2c);
    rd(ASP_OFS_RXBUF, 32'h44);
    rd(ASP_OFS_STATUS, 32'h0c);
    u_asp_remote.send(8'h5a, ^8'h5a, 1'b1);
    rd(ASP_OFS_STATUS, 32'h9c);
    rd(ASP_OFS_RXBUF, 32'h5a);
    u_asp_remote.send(8'h0f, ~^8'h0f, 1'b0);
    rd(ASP_OFS_STATUS, 32'h5c);
    rd(ASP_OFS_RXBUF, 32'h0f);
    // Receive disable written in mid-frame takes effect only after that frame.
    fork
      u_asp_remote.send(8'h81, ~^8'h81, 1'b1);
      begin
        repeat (600) @(posedge pclk);
        apb(1'b1, ASP_OFS_CTRL, 32'h08);
      end
    join
    rd(ASP_OFS_STATUS, 32'h1c);
    rd(ASP_OFS_RXBUF, 32'h81);
    u_asp_remote.send(8'h18, ~^8'h18, 1'b1);
    rd(ASP_OFS_STATUS, 32'h0c);
    chk(ntx, 7);
    chk(nrx, 7);
    stop_test;
  end
endmodule : tb_asp_top
